// ### verilog/dlc_dual_loop.v
// dual-loop pressure/flow controller with low-select output stage
//
// Functional notes
// - pressure and flow loops both compute every cycle, each with own inputs and tuning
// - smaller of the two loop outputs goes to the valve output; lower loop controls
// - function input selects outlet-pressure upper limit or inlet-pressure lower limit
// - outlet function: pressure loop reverse, positive error lowers its output
// - outlet function: flow loop reverse, flow above setpoint lowers its output
// - a loop driven upward keeps rising to full scale even when not selected
// - outputs recomputed every 0.5 s; error is pv minus setpoint; filter n is ten
// - output is proportional plus accumulated integral plus filtered derivative of error change
// - inlet function: pressure loop forward, flow loop stays reverse
`timescale 1ns/10ps
`default_nettype none

`include "dlc_defs.vh"

module dlc_dual_loop #(
    parameter integer CALC_CYCLES = `DLC_CALC_CYCLES
) (
    // clock and reset
    input  wire        clk_in,
    input  wire        rst_b_in,
    // function selection
    input  wire        function_sel_in,
    // pressure loop
    input  wire [15:0] pressure_loop_process_variable_in,
    input  wire [15:0] pressure_loop_setpoint_value_in,
    input  wire [15:0] pressure_loop_kp_in,
    input  wire [15:0] pressure_loop_ki_in,
    input  wire [15:0] pressure_loop_td_in,
    // flow loop
    input  wire [15:0] flow_loop_process_variable_in,
    input  wire [15:0] flow_loop_setpoint_value_in,
    input  wire [15:0] flow_loop_kp_in,
    input  wire [15:0] flow_loop_ki_in,
    input  wire [15:0] flow_loop_td_in,
    // outputs
    output reg  [15:0] valve_out,
    output reg  [15:0] pressure_loop_out,
    output reg  [15:0] flow_loop_out,
    output reg         pressure_in_control_out,
    output reg         cycle_done_out
);
    localparam        W        = 64;
    localparam integer CYC_LAST_I = CALC_CYCLES - 1;
    localparam [25:0] CYC_LAST   = CYC_LAST_I[25:0];
    localparam signed [W-1:0] FS_W    = {48'h0, `DLC_FULL_SCALE};
    localparam signed [W-1:0] N_W     = {56'h0, `DLC_FILTER_N};
    localparam signed [W-1:0] ZERO_W  = {W{1'b0}};

    // calculation cycle timer
    reg [25:0] tick_cnt;
    reg        tick;
    reg        func;

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            tick_cnt <= 26'h0000000;
            tick     <= 1'b0;
            func     <= `DLC_FUNC_OUTLET;
        end else begin
            tick <= 1'b0;
            if (tick_cnt == CYC_LAST) begin
                tick_cnt <= 26'h0000000;
                tick     <= 1'b1;
                func     <= function_sel_in;
            end else begin
                tick_cnt <= tick_cnt + 26'h0000001;
            end
        end
    end

    // per-loop inputs packed by loop index
    wire [31:0] pv_v = {flow_loop_process_variable_in, pressure_loop_process_variable_in};
    wire [31:0] sp_v = {flow_loop_setpoint_value_in, pressure_loop_setpoint_value_in};
    wire [31:0] kp_v = {flow_loop_kp_in, pressure_loop_kp_in};
    wire [31:0] ki_v = {flow_loop_ki_in, pressure_loop_ki_in};
    wire [31:0] td_v = {flow_loop_td_in, pressure_loop_td_in};

    // forward action only for the pressure loop in the inlet function
    wire [1:0] forward = {1'b0, func == `DLC_FUNC_INLET};

    wire [31:0] u_v;
    wire [1:0]  loop_done;

    genvar g;
    generate
        for (g = 0; g < 2; g = g + 1) begin : loop_g
            wire [15:0] coef;
            wire        coef_done;
            reg  [15:0] u;
            reg         done;
            reg  signed [W-1:0] i_acc;
            reg  signed [W-1:0] d_acc;
            reg  signed [W-1:0] e_prev;

            reg  signed [W-1:0] e_raw;
            reg  signed [W-1:0] e_eff;
            reg  signed [W-1:0] kp_w;
            reg  signed [W-1:0] ki_w;
            reg  signed [W-1:0] a_w;
            reg  signed [W-1:0] p_term;
            reg  signed [W-1:0] next_i;
            reg  signed [W-1:0] next_d;
            reg  signed [W-1:0] u_sum;
            reg  [15:0]         next_u;

            dlc_coef_div u_div (
                .clk_in   (clk_in),
                .rst_b_in (rst_b_in),
                .start_in (tick),
                .td_in    (td_v[16*g +: 16]),
                .coef_out (coef),
                .done_out (coef_done)
            );

            always @* begin
                e_raw  = {48'h0, pv_v[16*g +: 16]} - {48'h0, sp_v[16*g +: 16]};
                e_eff  = forward[g] ? e_raw : -e_raw;
                kp_w   = {48'h0, kp_v[16*g +: 16]};
                ki_w   = {48'h0, ki_v[16*g +: 16]};
                a_w    = {48'h0, coef};
                p_term = (kp_w * e_eff) >>> `DLC_GAIN_FRAC;
                next_i = i_acc + ((ki_w * e_eff) >>> `DLC_GAIN_FRAC);
                if (next_i < ZERO_W) begin
                    next_i = ZERO_W;
                end else if (next_i > FS_W) begin
                    next_i = FS_W;
                end
                next_d = ((a_w * d_acc) >>> `DLC_COEF_FRAC)
                       + ((a_w * N_W * kp_w * (e_eff - e_prev))
                          >>> (`DLC_COEF_FRAC + `DLC_GAIN_FRAC));
                u_sum  = p_term + next_i + next_d;
                // saturate at 100 % even while the other loop holds the valve
                if (u_sum < ZERO_W) begin
                    next_u = 16'h0000;
                end else if (u_sum > FS_W) begin
                    next_u = `DLC_FULL_SCALE;
                end else begin
                    next_u = u_sum[15:0];
                end
            end

            always @(posedge clk_in or negedge rst_b_in) begin
                if (!rst_b_in) begin
                    u      <= 16'h0000;
                    done   <= 1'b0;
                    i_acc  <= ZERO_W;
                    d_acc  <= ZERO_W;
                    e_prev <= ZERO_W;
                end else begin
                    done <= 1'b0;
                    // both loops update each cycle, selected or not
                    if (coef_done) begin
                        u      <= next_u;
                        i_acc  <= next_i;
                        d_acc  <= next_d;
                        e_prev <= e_eff;
                        done   <= 1'b1;
                    end
                end
            end

            assign u_v[16*g +: 16] = u;
            assign loop_done[g]    = done;
        end
    endgenerate

    wire [15:0] p_u = u_v[16*`DLC_LOOP_PRESSURE +: 16];
    wire [15:0] f_u = u_v[16*`DLC_LOOP_FLOW +: 16];

    // low-select stage, updated once both loops have finished
    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            valve_out               <= 16'h0000;
            pressure_loop_out       <= 16'h0000;
            flow_loop_out           <= 16'h0000;
            pressure_in_control_out <= 1'b0;
            cycle_done_out          <= 1'b0;
        end else begin
            cycle_done_out <= 1'b0;
            if (&loop_done) begin
                pressure_loop_out       <= p_u;
                flow_loop_out           <= f_u;
                pressure_in_control_out <= p_u < f_u;
                valve_out               <= (p_u < f_u) ? p_u : f_u;
                cycle_done_out          <= 1'b1;
            end
        end
    end
endmodule // dlc_dual_loop

`default_nettype wire

// ### include/dlc_defs.vh
// constants shared by the dual-loop low-select controller
`ifndef DLC_DEFS_VH
`define DLC_DEFS_VH

// full scale of every loop output and of the valve output (100 %)
`define DLC_FULL_SCALE      16'hffff

// calculation cycle time and clock rate
`define DLC_CALC_CYCLE_MS   500
`define DLC_CLK_MHZ         100
`define DLC_CALC_CYCLES     (`DLC_CALC_CYCLE_MS * `DLC_CLK_MHZ * 1000)

// derivative filter constant and cycle time in tenths of a second
`define DLC_FILTER_N        8'h0a
`define DLC_CYCLE_DS        8'h05

// function selection codes
`define DLC_FUNC_OUTLET     1'b0
`define DLC_FUNC_INLET      1'b1

// loop indices within the generate loop
`define DLC_LOOP_PRESSURE   0
`define DLC_LOOP_FLOW       1

// fixed-point fraction bits
`define DLC_GAIN_FRAC       8
`define DLC_COEF_FRAC       16

`endif

// ### verilog/dlc_coef_div.v
// serial divider for the derivative filter coefficient td / (td + n*t)
`timescale 1ns/10ps
`default_nettype none

`include "dlc_defs.vh"

module dlc_coef_div (
    // clock and reset
    input  wire        clk_in,
    input  wire        rst_b_in,
    // request
    input  wire        start_in,
    input  wire [15:0] td_in,
    // answer
    output reg  [15:0] coef_out,
    output reg         done_out
);
    // n times t in tenths of a second, fits eight bits
    localparam [16:0] FILTER_SPAN = {9'h000, `DLC_FILTER_N * `DLC_CYCLE_DS};

    reg [16:0] den;
    reg [17:0] rem;
    reg [15:0] quo;
    reg [4:0]  step;
    reg        busy;

    wire [17:0] shifted = {rem[16:0], 1'b0};
    wire        fits    = shifted >= {1'b0, den};

    always @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            den      <= 17'h00000;
            rem      <= 18'h00000;
            quo      <= 16'h0000;
            step     <= 5'h00;
            busy     <= 1'b0;
            coef_out <= 16'h0000;
            done_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (start_in && !busy) begin
                // quotient is below one since td < td + n*t
                den  <= {1'b0, td_in} + FILTER_SPAN;
                rem  <= {2'b00, td_in};
                quo  <= 16'h0000;
                step <= 5'h10;
                busy <= 1'b1;
            end else if (busy) begin
                rem  <= fits ? (shifted - {1'b0, den}) : shifted;
                quo  <= {quo[14:0], fits};
                step <= step - 5'h01;
                if (step == 5'h01) begin
                    busy     <= 1'b0;
                    coef_out <= {quo[14:0], fits};
                    done_out <= 1'b1;
                end
            end
        end
    end
endmodule // dlc_coef_div

`default_nettype wire

// ### bench/dlc_chk.sv
// assertion checker for the dual-loop low-select controller
`timescale 1ns/10ps
`default_nettype none
module dlc_chk #(
    parameter integer CALC_CYCLES = 40
) (
    // clock, reset and function
    input wire logic        clk_in,
    input wire logic        rst_b_in,
    input wire logic        function_sel_in,
    // loop inputs
    input wire logic [15:0] pressure_loop_process_variable_in,
    input wire logic [15:0] pressure_loop_setpoint_value_in,
    input wire logic [15:0] pressure_loop_kp_in,
    input wire logic [15:0] pressure_loop_td_in,
    input wire logic [15:0] flow_loop_process_variable_in,
    input wire logic [15:0] flow_loop_setpoint_value_in,
    input wire logic [15:0] flow_loop_kp_in,
    input wire logic [15:0] flow_loop_td_in,
    // outputs
    input wire logic [15:0] valve_out,
    input wire logic [15:0] pressure_loop_out,
    input wire logic [15:0] flow_loop_out,
    input wire logic        pressure_in_control_out,
    input wire logic        cycle_done_out
);
    logic [15:0] last_p, last_f;
    logic [31:0] gap;
    logic        seen;
    // integral-only loops move monotonically with the sign of the error
    wire p_int = (pressure_loop_kp_in == 16'h0) && (pressure_loop_td_in == 16'h0);
    wire f_int = (flow_loop_kp_in == 16'h0) && (flow_loop_td_in == 16'h0);
    wire p_hi  = pressure_loop_process_variable_in > pressure_loop_setpoint_value_in;
    wire f_hi  = flow_loop_process_variable_in > flow_loop_setpoint_value_in;
    wire upd   = cycle_done_out;
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            last_p <= 16'h0;
            last_f <= 16'h0;
            gap    <= 32'h0;
            seen   <= 1'b0;
        end else begin
            gap  <= upd ? 32'h0 : gap + 32'h1;
            seen <= seen | upd;
            if (upd) begin
                last_p <= pressure_loop_out;
                last_f <= flow_loop_out;
            end
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_b_in);
    property p_min;
        upd |-> valve_out == ((pressure_loop_out < flow_loop_out) ? pressure_loop_out : flow_loop_out);
    endproperty
    a_min: assert property (p_min) else $error("valve not the lower output");
    property p_ctl;
        upd |-> pressure_in_control_out == (pressure_loop_out < flow_loop_out);
    endproperty
    a_ctl: assert property (p_ctl) else $error("wrong loop in control");
    property p_pulse;
        upd |=> !upd;
    endproperty
    a_pulse: assert property (p_pulse) else $error("update flag longer than one cycle");
    property p_hold;
        !upd |-> $stable(valve_out) && $stable(pressure_loop_out) && $stable(flow_loop_out);
    endproperty
    a_hold: assert property (p_hold) else $error("outputs moved between updates");
    property p_period;
        upd && seen |-> gap == CALC_CYCLES - 1;
    endproperty
    a_period: assert property (p_period) else $error("update spacing wrong");
    property p_prev;
        upd && !function_sel_in && p_int && p_hi |-> pressure_loop_out <= last_p;
    endproperty
    a_prev: assert property (p_prev) else $error("pressure loop not reverse");
    property p_pfwd;
        upd && function_sel_in && p_int && p_hi |-> pressure_loop_out >= last_p;
    endproperty
    a_pfwd: assert property (p_pfwd) else $error("pressure loop not forward");
    property p_frev;
        upd && f_int && f_hi |-> flow_loop_out <= last_f;
    endproperty
    a_frev: assert property (p_frev) else $error("flow loop not reverse");
endmodule // dlc_chk
bind dlc_dual_loop dlc_chk #(.CALC_CYCLES(CALC_CYCLES)) u_chk (
    .clk_in                            (clk_in),
    .rst_b_in                          (rst_b_in),
    .function_sel_in                   (function_sel_in),
    .pressure_loop_process_variable_in (pressure_loop_process_variable_in),
    .pressure_loop_setpoint_value_in   (pressure_loop_setpoint_value_in),
    .pressure_loop_kp_in               (pressure_loop_kp_in),
    .pressure_loop_td_in               (pressure_loop_td_in),
    .flow_loop_process_variable_in     (flow_loop_process_variable_in),
    .flow_loop_setpoint_value_in       (flow_loop_setpoint_value_in),
    .flow_loop_kp_in                   (flow_loop_kp_in),
    .flow_loop_td_in                   (flow_loop_td_in),
    .valve_out                         (valve_out),
    .pressure_loop_out                 (pressure_loop_out),
    .flow_loop_out                     (flow_loop_out),
    .pressure_in_control_out           (pressure_in_control_out),
    .cycle_done_out                    (cycle_done_out)
);
`default_nettype wire

// ### bench/dlc_valve_model.sv
// control valve actuator model following the valve command
`timescale 1ns/10ps
`default_nettype none
module dlc_valve_model (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    // command and position
    input  wire logic [15:0] valve_cmd_in,
    output var  logic [15:0] position_out
);
    always_ff @(posedge clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            position_out <= 16'h0;
        end else begin
            position_out <= valve_cmd_in;
        end
    end
endmodule // dlc_valve_model
`default_nettype wire

// ### bench/tb.sv
// testbench for the dual-loop low-select controller
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic        clk_in = 1'b0;
    logic        rst_b_in = 1'b0;
    logic        fs = 1'b0;
    logic [15:0] ppv = 16'h0, psp = 16'h0, pkp = 16'h0100, pki = 16'h0, ptd = 16'h0;
    logic [15:0] fpv = 16'h0, fsp = 16'h0, fkp = 16'h0100, fki = 16'h0, ftd = 16'h0;
    wire  [15:0] valve, p_out, f_out, pos;
    wire         pctl, done;
    integer      mismatches = 0;
    integer      checks = 0;
    integer      cyc = 0;
    dlc_dual_loop #(.CALC_CYCLES(40)) DUT (.clk_in(clk_in), .rst_b_in(rst_b_in),
        .function_sel_in(fs), .pressure_loop_process_variable_in(ppv),
        .pressure_loop_setpoint_value_in(psp), .pressure_loop_kp_in(pkp),
        .pressure_loop_ki_in(pki), .pressure_loop_td_in(ptd),
        .flow_loop_process_variable_in(fpv), .flow_loop_setpoint_value_in(fsp),
        .flow_loop_kp_in(fkp), .flow_loop_ki_in(fki), .flow_loop_td_in(ftd),
        .valve_out(valve), .pressure_loop_out(p_out), .flow_loop_out(f_out),
        .pressure_in_control_out(pctl), .cycle_done_out(done));
    dlc_valve_model u_valve (.clk_in(clk_in), .rst_b_in(rst_b_in), .valve_cmd_in(valve),
        .position_out(pos));
    initial forever #5 clk_in = ~clk_in;
    task test_done;
        if (mismatches == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge clk_in) begin
        cyc = cyc + 1;
        if (cyc == 3000) begin
            mismatches = mismatches + 1;
            test_done;
        end
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks = checks + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("MISMATCH %0t got %h want %h", $time, seen, exp);
        end
    endtask
    // wait for n output updates, each within a bounded number of cycles
    task wait_done(input integer n);
        integer k, g;
        for (k = 0; k < n; k = k + 1) begin
            g = 0;
            do begin
                @(posedge clk_in);
                #1;
                g = g + 1;
            end while (done !== 1'b1 && g < 100);
            if (g == 100) begin
                mismatches = mismatches + 1;
                $display("MISMATCH %0t no update", $time);
            end
        end
    endtask
    task step(input logic [15:0] ep, input logic [15:0] ef, input integer n);
        logic [15:0] ev;
        ev = (ep < ef) ? ep : ef;
        wait_done(n);
        chk(p_out, ep);
        chk(f_out, ef);
        chk(valve, ev);
        chk({15'h0, pctl}, {15'h0, ep < ef});
        @(posedge clk_in);
        #1;
        chk(pos, ev);
    endtask
    initial begin
        repeat (16) @(posedge clk_in);
        #1;
        rst_b_in = 1'b1;
        ppv = 16'h03e8; psp = 16'h0514; fpv = 16'h01f4; fsp = 16'h0258;
        step(16'h012c, 16'h0064, 2);
        ppv = 16'h05dc; fpv = 16'h00c8;
        step(16'h0000, 16'h0190, 1);
        ppv = 16'h03e8; fpv = 16'h012c;
        step(16'h012c, 16'h012c, 1);
        fs = 1'b1; ppv = 16'h0514; psp = 16'h03e8; fpv = 16'h00c8;
        step(16'h012c, 16'h0190, 1);
        fs = 1'b0; pkp = 16'h0; fkp = 16'h0; pki = 16'h0100; fki = 16'h0100;
        ppv = 16'h9000; psp = 16'h1000; fpv = 16'h0; fsp = 16'h8000;
        step(16'h0000, 16'hffff, 2);
        ppv = 16'h0; psp = 16'h0100; fpv = 16'h8000; fsp = 16'h0;
        step(16'h0100, 16'h7fff, 1);
        step(16'h0200, 16'h0000, 1);
        // derivative with td = 5 s: coefficient one half, kick of 1280 then decay to 640
        pki = 16'h0;
        fki = 16'h0;
        pkp = 16'h0100;
        fkp = 16'h0100;
        ptd = 16'h0032;
        ppv = 16'h0;
        psp = 16'h0200;
        fpv = 16'h0;
        fsp = 16'h1000;
        step(16'h0900, 16'h1000, 1);
        step(16'h0680, 16'h1000, 1);
        // integral-only pressure loop in the inlet function rises with a positive error
        fs = 1'b1;
        pkp = 16'h0;
        ptd = 16'h0;
        pki = 16'h0400;
        ppv = 16'h0300;
        psp = 16'h0100;
        step(16'h0a00, 16'h1000, 1);
        rst_b_in = 1'b0;
        #2;
        chk(valve, 16'h0);
        chk(f_out, 16'h0);
        test_done;
    end
endmodule // tb
`default_nettype wire
